/* File: bench/scfg_ext_src.sv */
`timescale 1ns/100ps
module scfg_ext_src
  import scfg_pkg::*;
(
  input wire logic ref_clk,
  output logic ext_event_pin
);
  // Routed external line rests low between events
  initial ext_event_pin = 1'b0;

  // Spaced rising edge, then a held high level
  task automatic pulse(input int hi);
    repeat (ARM_TRIG_CYC) @(posedge ref_clk);
    ext_event_pin <= 1'b1;
    repeat ((hi < PULSE_MIN_CYC) ? PULSE_MIN_CYC : hi) @(posedge ref_clk);
    ext_event_pin <= 1'b0;
  endtask : pulse
endmodule : scfg_ext_src

/* File: bench/scfg_trigger_props.sv */
`timescale 1ns/100ps
module scfg_trigger_props
  import scfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mode_pin,
  input wire logic ext_event_pin,
  input wire logic [1:0] transfer_mode,
  input wire logic arm_enable,
  input wire logic config_end,
  input wire logic local_config_done,
  input wire logic chain_enable,
  input wire logic aux_b_enable,
  input wire logic local_config_done_chain_select,
  input wire logic boot_memory_clock_oe_n,
  input wire logic transfer_pulse,
  input wire logic armed
);
  // Port checks, all on the one clock
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_auto;
    transfer_mode == SCFG_MODE_AUTO && config_end |=> transfer_pulse;
  endproperty
  a_auto: assert property (p_auto) else $error("auto miss");
  property p_len;
    transfer_pulse |=> !transfer_pulse;
  endproperty
  a_len: assert property (p_len) else $error("pulse long");
  property p_chain;
    chain_enable |=> local_config_done_chain_select == !$past(local_config_done);
  endproperty
  a_chain: assert property (p_chain) else $error("chain bad");
  property p_boot_memory_clock;
    mode_pin [*3] |=> !boot_memory_clock_oe_n;
  endproperty
  a_boot_memory_clock: assert property (p_boot_memory_clock) else $error("pin b idle");
  property p_float;
    (!mode_pin && !aux_b_enable) [*3] |=> boot_memory_clock_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("pin b driven");
  property p_arm;
    transfer_mode == SCFG_MODE_EVENT && !arm_enable && config_end |=> armed;
  endproperty
  a_arm: assert property (p_arm) else $error("not armed");
  property p_once;
    transfer_pulse |-> !armed;
  endproperty
  a_once: assert property (p_once) else $error("still armed");
  property p_exec;
    transfer_mode == SCFG_MODE_EVENT && !arm_enable && armed &&
      $rose(ext_event_pin) |-> ##[1:4] transfer_pulse;
  endproperty
  a_exec: assert property (p_exec) else $error("exec late");
endmodule : scfg_trigger_props

bind scfg_trigger scfg_trigger_props u_props (.ref_clk, .reset, .mode_pin,
  .ext_event_pin, .transfer_mode, .arm_enable, .config_end,
  .local_config_done, .chain_enable, .aux_b_enable,
  .local_config_done_chain_select, .boot_memory_clock_oe_n,
  .transfer_pulse, .armed);

/* File: bench/shadow_config_transfer_trigger_tb_top.sv */
`timescale 1ns/100ps
module shadow_config_transfer_trigger_tb_top import scfg_pkg::*;;
  logic ref_clk, reset, mode_pin, ext_event_pin, arm_enable, ext_is_arm;
  logic int_arm, int_trig, config_end, local_config_done, chain_enable;
  logic aux_b_enable, comparator_in, autonull_done, ignored_clear;
  logic [1:0] transfer_mode, aux_a_sel, aux_b_sel;
  logic [DIV_W-1:0] clk_a_ratio, clk_b_ratio, boot_memory_clock_ratio;
  logic local_config_done_chain_select, aux_digital_out_a, transfer_pulse;
  logic boot_memory_clock, boot_memory_clock_oe_n, armed, trigger_ignored;
  int error_cnt = 0;
  int total_checks = 0;
  int seen_cnt = 0;
  int exp_cnt = 0;
  int seed = 8884;
  int hi;
  logic e;

  scfg_trigger dut (.ref_clk, .reset, .mode_pin, .ext_event_pin,
    .transfer_mode, .arm_enable, .ext_is_arm, .int_arm, .int_trig,
    .config_end, .local_config_done, .chain_enable, .aux_a_sel, .aux_b_sel,
    .aux_b_enable, .clk_a_ratio, .clk_b_ratio, .boot_memory_clock_ratio,
    .comparator_in, .autonull_done, .ignored_clear,
    .local_config_done_chain_select, .aux_digital_out_a,
    .boot_memory_clock, .boot_memory_clock_oe_n, .transfer_pulse, .armed,
    .trigger_ignored);
  scfg_ext_src ext (.ref_clk, .ext_event_pin);

  // Clock and transfer counter
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (transfer_pulse === 1'b1) seen_cnt++;

  function automatic int rnd(int n);
    return int'($unsigned($random(seed)) % n);
  endfunction : rnd
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk_bit(string nm, logic x, logic y);
    total_checks++;
    if (y !== x) begin
      error_cnt++;
      $display("Error %s exp %b got %b", nm, x, y);
    end
  endtask : chk_bit
  task automatic chk_cnt(int x, int y);
    total_checks++;
    if (y != x) begin
      error_cnt++;
      $display("Error transfers exp %0d got %0d", x, y);
    end
  endtask : chk_cnt
  // One-cycle strobes: clear, trig, arm, end byte
  task automatic strobe(logic [3:0] s);
    @(posedge ref_clk);
    {ignored_clear, int_trig, int_arm, config_end} <= s;
    @(posedge ref_clk);
    {ignored_clear, int_trig, int_arm, config_end} <= 4'h0;
  endtask : strobe
  task automatic fire();
    ext.pulse(1 + rnd(3));
    cyc(5);
  endtask : fire
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Watchdog
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    {mode_pin, arm_enable, ext_is_arm, int_arm, int_trig, config_end} = 6'h00;
    {local_config_done, chain_enable, aux_b_enable, comparator_in} = 4'h0;
    {autonull_done, ignored_clear} = 2'h0;
    transfer_mode = SCFG_MODE_AUTO;
    aux_a_sel = AUX_SEL_XFER;
    aux_b_sel = AUX_SEL_XFER;
    clk_a_ratio = DIV_RESET;
    clk_b_ratio = DIV_RESET;
    boot_memory_clock_ratio = DIV_RESET;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(1);
    chk_bit("oe_n", 1'b1, boot_memory_clock_oe_n);
    chk_bit("armed", 1'b0, armed);
    strobe(4'h1);
    cyc(2);
    exp_cnt++;
    chk_cnt(exp_cnt, seen_cnt);
    @(posedge ref_clk);
    transfer_mode <= SCFG_MODE_EVENT;
    strobe(4'h1);
    cyc(1);
    chk_bit("armed", 1'b1, armed);
    fire();
    exp_cnt++;
    chk_cnt(exp_cnt, seen_cnt);
    chk_bit("armed", 1'b0, armed);
    fire();
    chk_cnt(exp_cnt, seen_cnt);
    chk_bit("ignored", 1'b1, trigger_ignored);
    strobe(4'h8);
    cyc(1);
    chk_bit("ignored", 1'b0, trigger_ignored);
    // Arming on: internal arm, internal trigger refused; then external arm, internal trigger
    @(posedge ref_clk);
    arm_enable <= 1'b1;
    strobe(4'h2);
    strobe(4'h4);
    cyc(2);
    chk_bit("armed", 1'b1, armed);
    fire();
    exp_cnt++;
    chk_cnt(exp_cnt, seen_cnt);
    @(posedge ref_clk);
    ext_is_arm <= 1'b1;
    fire();
    chk_bit("armed", 1'b1, armed);
    strobe(4'h4);
    cyc(1);
    exp_cnt++;
    chk_cnt(exp_cnt, seen_cnt);
    chk_bit("armed", 1'b0, armed);
    // Clock sync with random ratios
    @(posedge ref_clk);
    transfer_mode <= SCFG_MODE_CLKSYNC;
    clk_a_ratio <= 9'(1 + rnd(4));
    clk_b_ratio <= 9'(1 + rnd(4));
    boot_memory_clock_ratio <= 9'(1 + rnd(8));
    strobe(4'h1);
    for (int i = 0; i < 40 && seen_cnt == exp_cnt; i++) begin
      cyc(1);
    end
    exp_cnt++;
    chk_cnt(exp_cnt, seen_cnt);
    cyc(20);
    chk_cnt(exp_cnt, seen_cnt);
    // Output pin sources, random levels
    @(posedge ref_clk);
    transfer_mode <= 2'h3;
    clk_a_ratio <= DIV_RESET;
    aux_b_enable <= 1'b1;
    repeat (8) begin
      @(posedge ref_clk);
      e = rnd(2) != 0;
      aux_a_sel <= e ? AUX_SEL_DONE : AUX_SEL_CMP;
      aux_b_sel <= e ? AUX_SEL_DONE : AUX_SEL_CMP;
      chain_enable <= rnd(2) != 0;
      local_config_done <= rnd(2) != 0;
      autonull_done <= rnd(2) != 0;
      comparator_in <= rnd(2) != 0;
      cyc(6);
      e = aux_a_sel[1] ? autonull_done : comparator_in;
      chk_bit("pin_b", e, boot_memory_clock);
      e = chain_enable ? !local_config_done : e;
      chk_bit("pin_a", e, local_config_done_chain_select);
      chk_bit("dout_a", e, aux_digital_out_a);
    end
    @(posedge ref_clk);
    aux_b_enable <= 1'b0;
    cyc(4);
    chk_bit("oe_n", 1'b1, boot_memory_clock_oe_n);
    @(posedge ref_clk);
    mode_pin <= 1'b1;
    aux_b_enable <= 1'b1;
    cyc(4);
    chk_bit("oe_n", 1'b0, boot_memory_clock_oe_n);
    hi = 0;
    repeat (20) begin
      e = boot_memory_clock;
      cyc(1);
      if (e !== boot_memory_clock) hi++;
    end
    chk_bit("boot_memory_clock", 1'b1, hi > 0);
    final_report();
  end
endmodule : shadow_config_transfer_trigger_tb_top

/* File: hdl/scfg_clkdiv.sv */
`timescale 1ns/100ps
module scfg_clkdiv
  import scfg_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] ratio,
  output logic tick,
  output logic level
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
    logic level;
  } scfg_div_t;

  scfg_div_t div_r;
  scfg_div_t div_nxt;
  logic [W-1:0] last;

  // Ratio zero is treated as one
  assign last = (ratio == '0) ? '0 : ratio - 1'b1;

  // Count ref_clk cycles, pulse at wrap, level is high first half
  always_comb begin
    div_nxt = div_r;
    div_nxt.tick = 1'b0;
    if (div_r.cnt >= last) begin
      div_nxt.cnt = '0;
      div_nxt.tick = 1'b1;
    end else begin
      div_nxt.cnt = div_r.cnt + 1'b1;
    end
    div_nxt.level = (div_nxt.cnt < ((last >> 1) + 1'b1)) ^ (last == '0) ?
                    1'b1 : 1'b0;
    if (last == '0) begin
      div_nxt.level = ~div_r.level;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = div_r.tick;
  assign level = div_r.level;

endmodule : scfg_clkdiv

/* File: hdl/scfg_outsel.sv */
`timescale 1ns/100ps
module scfg_outsel
  import scfg_pkg::*;
(
  input wire logic [1:0] sel,
  input wire logic clk_a,
  input wire logic cmp,
  input wire logic xfer,
  input wire logic done,
  output logic q
);

  // Pick one of four internal signals for export
  always_comb begin
    unique case (sel)
      AUX_SEL_CLKA: q = clk_a;
      AUX_SEL_CMP: q = cmp;
      AUX_SEL_XFER: q = xfer;
      AUX_SEL_DONE: q = done;
    endcase
  end

endmodule : scfg_outsel

/* File: hdl/scfg_pkg.sv */
package scfg_pkg;

  // Clock rate of ref_clk
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned REF_CLK_PS = 1_000_000_000 / (REF_CLK_HZ / 1000);

  // Printed times, in ns
  localparam int unsigned T_PULSE_MIN_NS = 5;
  localparam int unsigned T_ARM_TRIG_MIN_NS = 10;
  localparam int unsigned T_EXEC_DLY_MAX_NS = 20;
  localparam int unsigned T_EXEC_DLY_TYP_NS = 10;
  localparam int unsigned T_PTR_MIN_NS = 10;

  // Least times round up, longest times round down, never below one
  function automatic int unsigned scfg_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + REF_CLK_PS - 1) / REF_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : scfg_cyc_up

  function automatic int unsigned scfg_cyc_dn(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000) / REF_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : scfg_cyc_dn

  localparam int unsigned PULSE_MIN_CYC = scfg_cyc_up(T_PULSE_MIN_NS);
  localparam int unsigned ARM_TRIG_CYC = scfg_cyc_up(T_ARM_TRIG_MIN_NS);
  localparam int unsigned EXEC_DLY_CYC = scfg_cyc_dn(T_EXEC_DLY_MAX_NS);
  localparam int unsigned PTR_CYC = scfg_cyc_up(T_PTR_MIN_NS);

  // Execute pulse length in cycles (one period guaranteed)
  localparam logic [1:0] EXEC_LEN = 2'h1;

  // Divider ratio field
  localparam int unsigned DIV_W = 9;
  localparam logic [DIV_W-1:0] DIV_RESET = 9'h001;

  // Transfer trigger modes
  typedef enum logic [1:0] {
    SCFG_MODE_AUTO = 2'h0,
    SCFG_MODE_EVENT = 2'h1,
    SCFG_MODE_CLKSYNC = 2'h2
  } scfg_mode_t;

  // Auxiliary output sources
  localparam logic [1:0] AUX_SEL_CLKA = 2'h0;
  localparam logic [1:0] AUX_SEL_CMP = 2'h1;
  localparam logic [1:0] AUX_SEL_XFER = 2'h2;
  localparam logic [1:0] AUX_SEL_DONE = 2'h3;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    SCFG_IDLE = 3'h1,
    SCFG_ARMED = 3'h2,
    SCFG_EXEC = 3'h4
  } scfg_state_t;

endpackage : scfg_pkg

/* File: hdl/scfg_trigger.sv */
// Functional notes
// - Pin A carries inverted local-config-done as chain select for the next device.
// - Without chaining, pin A becomes a general digital output.
// - Boot memory clock is driven only while the mode input is high.
// - Auxiliary output B is unavailable on its pin while mode is high.
// - Mode low, B disabled: pin B undriven, weak pull-down holds it low.
// - Each aux output exports clock A, comparator, transfer pulse or done.
// - Comparator is clocked by a programmable divide of the master clock.
// - Without external arm, arming is set automatically at config end.
// - Execute follows trigger rising edge within 20 ns, typically 10 ns; here it comes three ref_clk cycles (300 ns) after the edge.
// - Execute pulse lasts one to two master clock periods.
// - After a transfer the arm circuit resets, ready within 10 ns.
// - Automatic mode: transfer right after the stream end byte.
// - Event mode, arming off: end byte arms, external signal triggers.
// - Arming on, external is trigger: arming comes only from inside.
// - Arming on, external is arm: trigger comes only from inside.
// - Clock-sync mode: transfer at first alignment of internal clocks.
`timescale 1ns/100ps
module scfg_trigger
  import scfg_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mode_pin,
  input wire logic ext_event_pin,
  input wire logic [1:0] transfer_mode,
  input wire logic arm_enable,
  input wire logic ext_is_arm,
  input wire logic int_arm,
  input wire logic int_trig,
  input wire logic config_end,
  input wire logic local_config_done,
  input wire logic chain_enable,
  input wire logic [1:0] aux_a_sel,
  input wire logic [1:0] aux_b_sel,
  input wire logic aux_b_enable,
  input wire logic [W-1:0] clk_a_ratio,
  input wire logic [W-1:0] clk_b_ratio,
  input wire logic [W-1:0] boot_memory_clock_ratio,
  input wire logic comparator_in,
  input wire logic autonull_done,
  input wire logic ignored_clear,
  output logic local_config_done_chain_select,
  output logic aux_digital_out_a,
  output logic boot_memory_clock,
  output logic boot_memory_clock_oe_n,
  output logic transfer_pulse,
  output logic armed,
  output logic trigger_ignored
);

  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    scfg_state_t state;
    logic sync_pend;
    logic [1:0] exec_cnt;
    logic exec;
    logic cmp_q;
    logic pin_a;
    logic pin_b;
    logic pin_b_oe_n;
    logic ignored;
  } scfg_reg_t;

  localparam scfg_reg_t REG_RESET = '{
    mode_s1: 1'b0,
    mode_s2: 1'b0,
    ext_s1: 1'b0,
    ext_s2: 1'b0,
    ext_s3: 1'b0,
    state: SCFG_IDLE,
    sync_pend: 1'b0,
    exec_cnt: 2'h0,
    exec: 1'b0,
    cmp_q: 1'b0,
    pin_a: 1'b1,
    pin_b: 1'b0,
    pin_b_oe_n: 1'b1,
    ignored: 1'b0
  };

  scfg_reg_t st_r;
  scfg_reg_t st_nxt;

  logic clk_a_tick;
  logic clk_a_lvl;
  logic clk_b_tick;
  logic clk_b_lvl;
  logic mem_lvl;
  logic aux_a_src;
  logic aux_b_src;

  // Module clock A, also clocks the comparator module
  scfg_clkdiv #(
    .W(W)
  ) u_div_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .ratio(clk_a_ratio),
    .tick(clk_a_tick),
    .level(clk_a_lvl)
  );

  // Secondary module clock, used for alignment search
  scfg_clkdiv #(
    .W(W)
  ) u_div_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .ratio(clk_b_ratio),
    .tick(clk_b_tick),
    .level(clk_b_lvl)
  );

  // Boot memory clock source
  scfg_clkdiv #(
    .W(W)
  ) u_div_mem (
    .ref_clk(ref_clk),
    .reset(reset),
    .ratio(boot_memory_clock_ratio),
    .tick(),
    .level(mem_lvl)
  );

  // Export selectors for both auxiliary outputs
  scfg_outsel u_sel_a (
    .sel(aux_a_sel),
    .clk_a(clk_a_lvl),
    .cmp(st_r.cmp_q),
    .xfer(st_r.exec),
    .done(autonull_done),
    .q(aux_a_src)
  );

  scfg_outsel u_sel_b (
    .sel(aux_b_sel),
    .clk_a(clk_a_lvl),
    .cmp(st_r.cmp_q),
    .xfer(st_r.exec),
    .done(autonull_done),
    .q(aux_b_src)
  );

  // Decoded trigger and arm sources
  logic ext_rise;
  logic ext_arm_mode;
  logic arm_evt;
  logic trig_evt;
  logic is_auto;
  logic is_event;
  logic is_sync;
  logic aligned;

  // Rising edge of the synchronised external signal
  assign ext_rise = st_r.ext_s2 & ~st_r.ext_s3;
  assign is_auto = (transfer_mode == SCFG_MODE_AUTO);
  assign is_event = (transfer_mode == SCFG_MODE_EVENT);
  assign is_sync = (transfer_mode == SCFG_MODE_CLKSYNC);
  assign ext_arm_mode = arm_enable & ext_is_arm;
  // Both module clocks wrap together
  assign aligned = clk_a_tick & clk_b_tick;

  // Arm and trigger routing for event-driven mode
  always_comb begin
    if (!arm_enable) begin
      arm_evt = config_end;
      trig_evt = ext_rise;
    end else if (!ext_is_arm) begin
      arm_evt = int_arm | config_end;
      trig_evt = ext_rise;
    end else begin
      arm_evt = ext_rise;
      trig_evt = int_trig;
    end
  end

  // Next-state logic for all block state
  always_comb begin
    st_nxt = st_r;

    // Clear first so that a set in this cycle wins
    if (ignored_clear) begin
      st_nxt.ignored = 1'b0;
    end

    // Two-stage synchronisers for pin inputs
    st_nxt.mode_s1 = mode_pin;
    st_nxt.mode_s2 = st_r.mode_s1;
    st_nxt.ext_s1 = ext_event_pin;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;

    // Comparator sampled on module clock A
    if (clk_a_tick) begin
      st_nxt.cmp_q = comparator_in;
    end

    st_nxt.exec = 1'b0;

    unique case (st_r.state)
      SCFG_IDLE: begin
        if (is_auto && config_end) begin
          st_nxt.state = SCFG_EXEC;
          st_nxt.exec = 1'b1;
          st_nxt.exec_cnt = EXEC_LEN;
        end else if (is_sync && (config_end || st_r.sync_pend)) begin
          if (aligned) begin
            st_nxt.state = SCFG_EXEC;
            st_nxt.exec = 1'b1;
            st_nxt.exec_cnt = EXEC_LEN;
            st_nxt.sync_pend = 1'b0;
          end else begin
            st_nxt.sync_pend = 1'b1;
          end
        end else if (is_event && arm_evt) begin
          // Trigger in the arming cycle is not taken
          st_nxt.state = SCFG_ARMED;
        end else if (is_event && trig_evt) begin
          st_nxt.ignored = 1'b1;
        end
        if (!is_sync) begin
          st_nxt.sync_pend = 1'b0;
        end
      end
      SCFG_ARMED: begin
        if (!is_event) begin
          st_nxt.state = SCFG_IDLE;
        end else if (trig_evt) begin
          // Execute on the edge after the synchronised trigger
          st_nxt.state = SCFG_EXEC;
          st_nxt.exec = 1'b1;
          st_nxt.exec_cnt = EXEC_LEN;
        end
      end
      SCFG_EXEC: begin
        // Hold pulse for its length, then reset the arm circuit
        if (st_r.exec_cnt > 2'h1) begin
          st_nxt.exec = 1'b1;
          st_nxt.exec_cnt = st_r.exec_cnt - 2'h1;
        end else begin
          st_nxt.exec_cnt = 2'h0;
          st_nxt.state = SCFG_IDLE;
        end
        if (trig_evt && is_event) begin
          st_nxt.ignored = 1'b1;
        end
      end
      default: begin
        st_nxt.state = SCFG_IDLE;
      end
    endcase

    // Pin A: chain select or general output
    if (chain_enable) begin
      st_nxt.pin_a = ~local_config_done;
    end else begin
      st_nxt.pin_a = aux_a_src;
    end

    // Pin B: boot memory clock, aux output or released
    if (st_r.mode_s2) begin
      st_nxt.pin_b = mem_lvl;
      st_nxt.pin_b_oe_n = 1'b0;
    end else if (aux_b_enable) begin
      st_nxt.pin_b = aux_b_src;
      st_nxt.pin_b_oe_n = 1'b0;
    end else begin
      st_nxt.pin_b = 1'b0;
      st_nxt.pin_b_oe_n = 1'b1;
    end
  end

  // Single register for the whole state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= REG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign local_config_done_chain_select = st_r.pin_a;
  assign aux_digital_out_a = st_r.pin_a;
  assign boot_memory_clock = st_r.pin_b;
  assign boot_memory_clock_oe_n = st_r.pin_b_oe_n;
  assign transfer_pulse = st_r.exec;
  assign armed = st_r.state[1]; // One-hot armed bit
  assign trigger_ignored = st_r.ignored;

endmodule : scfg_trigger
